// file: core/mtsp_interval_timer.sv
`timescale 1ns/1ps
module mtsp_interval_timer
    import mtsp_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic                i_rstn,
    input  wire logic                i_run,
    input  wire logic                i_tick,
    input  wire logic [PERIOD_W-1:0] i_period,
    output logic                     o_fire
);
    logic [PERIOD_W-1:0] count;
    logic [PERIOD_W-1:0] next_count;
    logic                next_fire;
    logic [PERIOD_W-1:0] last;

    // a zero period would wrap to 65536 ticks; treat it as one tick
    assign last = (i_period == '0) ? '0 : i_period - 16'h0001;

    always_comb begin
        next_count = count;
        next_fire  = 1'b0;
        if (!i_run) begin
            next_count = '0;
        end else if (i_tick) begin
            if (count >= last) begin
                next_count = '0;
                next_fire  = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            count  <= '0;
            o_fire <= 1'b0;
        end else begin
            count  <= next_count;
            o_fire <= next_fire;
        end
    end
endmodule

// file: core/mtsp_time_sync.sv
// Notes on behaviour
// - port rate is 187.5 kbps unless another rate is configured
// - 19.2 kbps selectable for small legacy controllers
// - high-end variants accept configured rates up to 12 Mbps
// - bus configuration including rate is broadcast unasked, periodically
// - combined port powers up in multipoint function
// - time synchronization disabled until a role is configured
// - each interface configurable as time master or time slave
// - slave accepts frames from one master and loads time-of-day
// - master broadcasts a sync frame once per configured interval
// - no master frames while the real-time clock is unset
// - clock marked unset at delivery, factory reset and firmware update
// - first time write via system call or station starts broadcasting
// - time set by another master as slave also starts broadcasting
// - sync on multipoint, fieldbus, ethernet ports and the rack
// - slave role on at most one interface; reject otherwise
// - fieldbus slave leaves only master roles elsewhere
// - ethernet time protocol counts as slave; others master only
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module mtsp_time_sync
    import mtsp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic              i_clock,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [DATA_W-1:0]      o_rdata,
    input  wire logic              i_factory_reset,
    input  wire logic              i_fw_update,
    input  wire logic              i_station_set,
    input  wire logic [31:0]       i_station_tod,
    input  wire mtsp_rx_s          i_rx,
    output mtsp_sync_tx_s          o_sync_tx,
    output mtsp_bcast_s            o_bcast,
    output logic                   o_fieldbus_mode,
    output logic [1:0]             o_rate
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [1:0]          rate,       next_rate;
    logic                fb_mode,    next_fb_mode;
    logic [7:0]          roles,      next_roles;
    logic [PERIOD_W-1:0] interval,   next_interval;
    logic [31:0]         tod,        next_tod;
    logic                rtc_set,    next_rtc_set;
    logic                cfg_err,    next_cfg_err;
    logic                locked,     next_locked;
    logic [6:0]          master_src, next_master_src;
    logic [DATA_W-1:0]   next_rdata;
    logic [31:0]         tick_cnt,   next_tick_cnt;
    logic                tick;
    logic                sync_fire;
    logic                bcast_fire;
    logic [3:0]          is_master;
    logic [3:0]          is_slave;
    logic [3:0]          wr_master;
    logic [3:0]          wr_slave;
    logic [3:0]          wr_bad_code;
    logic                wr_roles_ok;
    logic                slave_any;
    logic [1:0]          slave_if;
    logic                rx_accept;
    logic                sw_time_wr;
    logic [31:0]         rate_bps;
    mtsp_sync_tx_s       next_sync_tx;
    mtsp_bcast_s         next_bcast;

    // ----------------------------------------------------------------
    // role decode
    // ----------------------------------------------------------------
    // four sync interfaces
    genvar g;
    generate
        for (g = 0; g < NUM_IF; g++) begin : g_if
            assign is_master[g]   = roles[g*ROLE_W +: ROLE_W] == ROLE_MASTER;
            assign is_slave[g]    = roles[g*ROLE_W +: ROLE_W] == ROLE_SLAVE;
            assign wr_master[g]   = i_wdata[g*ROLE_W +: ROLE_W] == ROLE_MASTER;
            assign wr_slave[g]    = i_wdata[g*ROLE_W +: ROLE_W] == ROLE_SLAVE;
            assign wr_bad_code[g] = !wr_master[g] && !wr_slave[g]
                                  && i_wdata[g*ROLE_W +: ROLE_W] != ROLE_OFF;
        end
    endgenerate

    assign wr_roles_ok = ((wr_slave & (wr_slave - 4'h1)) == 4'h0) && (wr_bad_code == 4'h0);
    assign slave_any   = is_slave != 4'h0;

    always_comb begin
        slave_if = IF_MULTIPOINT;
        for (int i = 0; i < NUM_IF; i++) begin
            if (is_slave[i]) begin
                slave_if = i[1:0];
            end
        end
    end

    assign rx_accept = i_rx.valid && slave_any && i_rx.iface == slave_if
                     && (!locked || i_rx.src == master_src);
    assign sw_time_wr = i_wr && i_addr == ADDR_TIME;

    // ----------------------------------------------------------------
    // millisecond tick and timers
    // ----------------------------------------------------------------
    always_comb begin
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
        end
    end
    assign tick = tick_cnt >= 32'(TICK_CYCLES - 1);

    mtsp_interval_timer u_sync_timer (
        .i_clock  (i_clock),
        .i_rstn   (i_rstn),
        .i_run    (rtc_set && is_master != 4'h0),
        .i_tick   (tick),
        .i_period (interval),
        .o_fire   (sync_fire)
    );

    mtsp_interval_timer u_bcast_timer (
        .i_clock  (i_clock),
        .i_rstn   (i_rstn),
        .i_run    (1'b1),
        .i_tick   (tick),
        .i_period (BCAST_PERIOD_MS),
        .o_fire   (bcast_fire)
    );

    // ----------------------------------------------------------------
    // register and clock state
    // ----------------------------------------------------------------
    always_comb begin
        next_rate       = rate;
        next_fb_mode    = fb_mode;
        next_roles      = roles;
        next_interval   = interval;
        next_tod        = tick ? tod + 32'h1 : tod;
        next_rtc_set    = rtc_set;
        next_cfg_err    = cfg_err;
        next_locked     = locked;
        next_master_src = master_src;
        // unset on factory reset or update
        if (i_factory_reset || i_fw_update) begin
            next_rtc_set = 1'b0;
        end
        if (i_wr) begin
            case (i_addr)
                ADDR_CTRL: begin
                    if (i_wdata[CTRL_RATE_LSB +: 2] == RATE_DEFAULT
                        || i_wdata[CTRL_RATE_LSB +: 2] == RATE_LEGACY
                        || (i_wdata[CTRL_RATE_LSB +: 2] == RATE_HIGH && HIGH_END_VARIANT)) begin
                        next_rate = i_wdata[CTRL_RATE_LSB +: 2];
                    end
                    next_fb_mode = i_wdata[CTRL_FIELDBUS];
                end
                ADDR_ROLE: begin
                    if (wr_roles_ok) begin
                        next_roles  = i_wdata[7:0];
                        next_locked = 1'b0;
                    end else begin
                        next_cfg_err = 1'b1;
                    end
                end
                ADDR_INTERVAL: begin
                    next_interval = i_wdata[PERIOD_W-1:0];
                end
                ADDR_STATUS: begin
                    if (i_wdata[STAT_CFG_ERR]) begin
                        next_cfg_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (sw_time_wr) begin
            next_tod     = i_wdata;
            next_rtc_set = 1'b1;
        end else if (i_station_set) begin
            next_tod     = i_station_tod;
            next_rtc_set = 1'b1;
        end else if (rx_accept) begin
            next_tod        = i_rx.tod;
            next_rtc_set    = 1'b1;
            next_locked     = 1'b1;
            next_master_src = i_rx.src;
        end
        // a rejected role write in the same cycle as a clear still flags
        if (i_wr && i_addr == ADDR_ROLE && !wr_roles_ok) begin
            next_cfg_err = 1'b1;
        end
    end

    always_comb begin
        case (i_addr)
            ADDR_CTRL:       next_rdata = {29'h0, fb_mode, rate};
            ADDR_ROLE:       next_rdata = {24'h0, roles};
            ADDR_INTERVAL:   next_rdata = {16'h0, interval};
            ADDR_TIME:       next_rdata = tod;
            ADDR_STATUS:     next_rdata = {29'h0, locked, cfg_err, rtc_set};
            ADDR_MASTER_SRC: next_rdata = {25'h0, master_src};
            default:         next_rdata = '0;
        endcase
        if (!i_rd) begin
            next_rdata = '0;
        end
    end

    // ----------------------------------------------------------------
    // outgoing frames
    // ----------------------------------------------------------------
    always_comb begin
        case (rate)
            RATE_LEGACY: rate_bps = RATE_LEGACY_BPS;
            RATE_HIGH:   rate_bps = RATE_HIGH_BPS;
            default:     rate_bps = RATE_DEFAULT_BPS;
        endcase
        // one frame per interval
        // a fire already in flight must not escape once the last master role is gone
        next_sync_tx.valid      = sync_fire && rtc_set && is_master != 4'h0;
        next_sync_tx.iface_mask = is_master;
        next_sync_tx.tod        = tod;
        next_bcast.valid         = bcast_fire;
        next_bcast.fieldbus_mode = fb_mode;
        next_bcast.rate_bps      = rate_bps;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rate       <= RATE_DEFAULT;
            fb_mode    <= 1'b0;
            roles      <= ROLE_RESET;
            interval   <= SYNC_INTERVAL_MS;
            tod        <= '0;
            rtc_set    <= 1'b0;
            cfg_err    <= 1'b0;
            locked     <= 1'b0;
            master_src <= SRC_NONE;
            tick_cnt   <= '0;
            o_rdata    <= '0;
            o_sync_tx  <= '0;
            o_bcast    <= '0;
        end else begin
            rate       <= next_rate;
            fb_mode    <= next_fb_mode;
            roles      <= next_roles;
            interval   <= next_interval;
            tod        <= next_tod;
            rtc_set    <= next_rtc_set;
            cfg_err    <= next_cfg_err;
            locked     <= next_locked;
            master_src <= next_master_src;
            tick_cnt   <= next_tick_cnt;
            o_rdata    <= next_rdata;
            o_sync_tx  <= next_sync_tx;
            o_bcast    <= next_bcast;
        end
    end

    assign o_fieldbus_mode = fb_mode;
    assign o_rate          = rate;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    unset_no_tx_a: assert property (o_sync_tx.valid |-> $past(rtc_set))
        else $error("sync frame sent with unset clock");
    one_slave_a: assert property ((is_slave & (is_slave - 4'h1)) == 4'h0)
        else $error("more than one slave interface");
    reject_cfg_a: assert property (i_wr && i_addr == ADDR_ROLE && !wr_roles_ok
        |=> cfg_err && $stable(roles))
        else $error("bad role write not rejected");
    fact_unset_a: assert property (i_factory_reset && !sw_time_wr && !i_station_set
        && !rx_accept |=> !rtc_set)
        else $error("clock still set after factory reset");
    first_set_a: assert property (sw_time_wr |=> rtc_set && tod == $past(i_wdata))
        else $error("time write did not set clock");
    slave_load_a: assert property (rx_accept && !sw_time_wr && !i_station_set
        |=> tod == $past(i_rx.tod) && rtc_set && locked)
        else $error("slave frame not loaded");
    wrong_if_a: assert property (i_rx.valid && i_rx.iface != slave_if && !sw_time_wr
        && !i_station_set && !tick |=> $stable(tod))
        else $error("frame from wrong interface loaded");
    other_src_a: assert property (locked && i_rx.src != master_src |-> !rx_accept)
        else $error("frame from second master accepted");
    bcast_rate_a: assert property (o_bcast.valid && $past(rate) == RATE_LEGACY
        |-> o_bcast.rate_bps == RATE_LEGACY_BPS)
        else $error("broadcast rate mismatch");
    no_role_tx_a: assert property (roles == ROLE_RESET |=> !o_sync_tx.valid)
        else $error("sync frame sent without role");

    cov_master_c: cover property (o_sync_tx.valid);
    cov_slave_c:  cover property (rx_accept ##1 locked);
    cov_reject_c: cover property (i_wr && i_addr == ADDR_ROLE && !wr_roles_ok);
endmodule

// file: include/mtsp_pkg.sv
package mtsp_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_ROLE       = 4'h1;
    localparam logic [3:0]  ADDR_INTERVAL   = 4'h2;
    localparam logic [3:0]  ADDR_TIME       = 4'h3;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_MASTER_SRC = 4'h5;

    // control fields
    localparam int          CTRL_RATE_LSB   = 0;
    localparam int          CTRL_FIELDBUS   = 2;
    // status fields
    localparam int          STAT_RTC_SET    = 0;
    localparam int          STAT_CFG_ERR    = 1;
    localparam int          STAT_LOCKED     = 2;

    // ----------------------------------------------------------------
    // interfaces and roles
    // ----------------------------------------------------------------
    localparam int          NUM_IF          = 4;
    localparam logic [1:0]  IF_MULTIPOINT   = 2'h0;
    localparam logic [1:0]  IF_FIELDBUS     = 2'h1;
    localparam logic [1:0]  IF_ETHERNET     = 2'h2;
    localparam logic [1:0]  IF_RACK         = 2'h3;
    localparam int          ROLE_W          = 2;
    localparam logic [1:0]  ROLE_OFF        = 2'h0;
    localparam logic [1:0]  ROLE_MASTER     = 2'h1;
    localparam logic [1:0]  ROLE_SLAVE      = 2'h2;
    localparam logic [7:0]  ROLE_RESET      = 8'h00;

    // ----------------------------------------------------------------
    // rates
    // ----------------------------------------------------------------
    localparam logic [1:0]  RATE_DEFAULT    = 2'h0;
    localparam logic [1:0]  RATE_LEGACY     = 2'h1;
    localparam logic [1:0]  RATE_HIGH       = 2'h2;
    localparam logic [31:0] RATE_DEFAULT_BPS = 32'h0002dc6c;
    localparam logic [31:0] RATE_LEGACY_BPS  = 32'h00004b00;
    localparam logic [31:0] RATE_HIGH_BPS    = 32'h00b71b00;
    localparam logic        HIGH_END_VARIANT = 1'b1;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLOCK_PERIOD_PS  = 4000;
    localparam int          TICK_TIME_US     = 1000;
    // microseconds to picoseconds, then whole clock periods per tick
    localparam int          TICK_CYCLES_DEF  = TICK_TIME_US * 1000000 / CLOCK_PERIOD_PS;
    localparam int          PERIOD_W         = 16;
    localparam logic [15:0] SYNC_INTERVAL_MS = 16'h000a;
    localparam logic [15:0] BCAST_PERIOD_MS  = 16'h0064;
    localparam logic [6:0]  SRC_NONE         = 7'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [1:0]  iface;
        logic [6:0]  src;
        logic [31:0] tod;
    } mtsp_rx_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  iface_mask;
        logic [31:0] tod;
    } mtsp_sync_tx_s;

    typedef struct packed {
        logic        valid;
        logic        fieldbus_mode;
        logic [31:0] rate_bps;
    } mtsp_bcast_s;

endpackage

// file: verification/mtsp_station_model.sv
`timescale 1ns/1ps
module mtsp_station_model
    import mtsp_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_send,
    input  wire logic [1:0]  i_iface,
    input  wire logic [6:0]  i_src,
    input  wire logic [31:0] i_tod,
    output mtsp_rx_s         o_rx
);
    mtsp_rx_s next_rx;

    // ----------------------------------------------------------------
    // frame shaping
    // ----------------------------------------------------------------
    // one frame per request
    always_comb begin
        next_rx.valid = i_send;
        if (i_send) begin
            next_rx.iface = i_iface;
            next_rx.src   = i_src;
            next_rx.tod   = i_tod;
        end else begin
            // idle fields are not held, so stale data can never pass as a frame
            next_rx.iface = ~o_rx.iface;
            next_rx.src   = ~o_rx.src;
            next_rx.tod   = ~o_rx.tod;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx <= '0;
        end else begin
            o_rx <= next_rx;
        end
    end
endmodule

// file: verification/mtsp_time_sync_tb.sv
`timescale 1ns/1ps
module mtsp_time_sync_tb
    import mtsp_pkg::*;
;
    logic              i_clock, i_rstn, i_wr, i_rd;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic              i_factory_reset, i_fw_update, i_station_set;
    logic [31:0]       i_station_tod;
    mtsp_rx_s          i_rx;
    mtsp_sync_tx_s     o_sync_tx;
    mtsp_bcast_s       o_bcast;
    logic              o_fieldbus_mode;
    logic [1:0]        o_rate;
    logic              m_send;
    logic [1:0]        m_iface;
    logic [6:0]        m_src;
    logic [31:0]       m_tod, d;
    int                n_errors, n_tests, n_tx, n, base;
    logic [7:0]        bad [5] = '{8'h0a, 8'h28, 8'h88, 8'h03, 8'h22};

    mtsp_time_sync #(.TICK_CYCLES(10)) mtsp_time_sync_i (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_factory_reset(i_factory_reset), .i_fw_update(i_fw_update),
        .i_station_set(i_station_set), .i_station_tod(i_station_tod), .i_rx(i_rx),
        .o_sync_tx(o_sync_tx), .o_bcast(o_bcast), .o_fieldbus_mode(o_fieldbus_mode),
        .o_rate(o_rate));
    mtsp_station_model mtsp_station_model_i (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_send(m_send), .i_iface(m_iface), .i_src(m_src), .i_tod(m_tod), .o_rx(i_rx));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        if (o_sync_tx.valid === 1'b1) n_tx <= n_tx + 1;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task summarize();
        if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock); i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clock); i_wr <= 1'b0;
        @(posedge i_clock); #1;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clock); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock); i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task send(input logic [1:0] f, input logic [6:0] s, input logic [31:0] t);
        @(posedge i_clock); m_send <= 1'b1; m_iface <= f; m_src <= s; m_tod <= t;
        @(posedge i_clock); m_send <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask
    // bounded wait for a sync frame (bc=0) or a broadcast (bc=1)
    task wait_ev(input bit bc, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge i_clock); #1;
            cnt++;
        end while (((bc ? o_bcast.valid : o_sync_tx.valid) !== 1'b1) && cnt < lim);
        if (cnt >= lim) begin
            n_errors++;
            $display("[ERR] %0t event wait ran out", $time);
            summarize();
        end
    endtask
    task quiet(input int cyc);
        base = n_tx;
        repeat (cyc) @(posedge i_clock);
        chk(n_tx - base, 0);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset();
        chk(o_rate, RATE_DEFAULT);
        chk(o_fieldbus_mode, 0);
        rd(ADDR_ROLE, d); chk(d, 0);
        rd(ADDR_STATUS, d); chk(d, 0);
        rd(ADDR_INTERVAL, d); chk(d[15:0], SYNC_INTERVAL_MS);
        wr(ADDR_TIME, 32'h40); quiet(150);
        @(posedge i_clock); i_factory_reset <= 1'b1;
        @(posedge i_clock); i_factory_reset <= 1'b0;
    endtask
    task t_rate();
        wr(ADDR_CTRL, 32'h1); chk(o_rate, RATE_LEGACY);
        wr(ADDR_CTRL, 32'h2); chk(o_rate, RATE_HIGH);
        wr(ADDR_CTRL, 32'h3); chk(o_rate, RATE_HIGH);
        wait_ev(1, 1100, n); chk(o_bcast.rate_bps, RATE_HIGH_BPS);
        wait_ev(1, 1100, n); chk(n, 1000);
        wr(ADDR_CTRL, 32'h5); chk(o_fieldbus_mode, 1);
        wait_ev(1, 1100, n); chk(o_bcast.rate_bps, RATE_LEGACY_BPS);
        chk(o_bcast.fieldbus_mode, 1);
        wr(ADDR_CTRL, 32'h0); chk(o_fieldbus_mode, 0);
        wait_ev(1, 1100, n); chk(o_bcast.rate_bps, RATE_DEFAULT_BPS);
    endtask
    task t_master();
        wr(ADDR_ROLE, 32'h01); wr(ADDR_INTERVAL, 32'h2);
        quiet(150);
        wr(ADDR_TIME, 32'h1234);
        rd(ADDR_STATUS, d); chk(d[0], 1);
        wait_ev(0, 40, n); chk(o_sync_tx.iface_mask, 4'h1);
        chk(32'(o_sync_tx.tod - 32'h1234) <= 5, 1);
        wait_ev(0, 40, n); chk(n, 20);
        wr(ADDR_ROLE, 32'h55);
        wait_ev(0, 40, n); chk(o_sync_tx.iface_mask, 4'hf);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clock); i_station_set <= 1'b1; i_station_tod <= 32'h777;
            @(posedge i_clock); i_station_set <= 1'b0;
            repeat (2) @(posedge i_clock);
            rd(ADDR_TIME, d); chk(32'(d - 32'h777) <= 1, 1);
            wait_ev(0, 40, n); chk(32'(o_sync_tx.tod - 32'h777) <= 5, 1);
            @(posedge i_clock); i_factory_reset <= (k == 0); i_fw_update <= (k == 1);
            @(posedge i_clock); i_factory_reset <= 1'b0; i_fw_update <= 1'b0;
            rd(ADDR_STATUS, d); chk(d[0], 0);
            quiet(60);
        end
    endtask
    task t_slave();
        wr(ADDR_ROLE, 32'h09);
        send(IF_MULTIPOINT, 7'h05, 32'h100);
        rd(ADDR_STATUS, d); chk(d, 0);
        send(IF_FIELDBUS, 7'h05, 32'h500);
        rd(ADDR_STATUS, d); chk(d, 32'h5);
        rd(ADDR_MASTER_SRC, d); chk(d, 32'h5);
        send(IF_FIELDBUS, 7'h06, 32'h9000);
        rd(ADDR_TIME, d); chk(32'(d - 32'h500) <= 2, 1);
        rd(ADDR_MASTER_SRC, d); chk(d, 32'h5);
        wait_ev(0, 40, n); chk(o_sync_tx.iface_mask, 4'h1);
    endtask
    task t_reject();
        foreach (bad[k]) begin
            wr(ADDR_ROLE, {24'h0, bad[k]});
            rd(ADDR_ROLE, d); chk(d, 32'h09);
            rd(ADDR_STATUS, d); chk(d[1], 1);
            wr(ADDR_STATUS, 32'h2);
            rd(ADDR_STATUS, d); chk(d[1], 0);
        end
    endtask

    initial begin
        {i_rstn, i_wr, i_rd, i_factory_reset, i_fw_update, i_station_set, m_send} = '0;
        {i_addr, i_wdata, i_station_tod, m_iface, m_src, m_tod} = '0;
        {n_errors, n_tests, n_tx} = '0;
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock); #1;
        t_reset();
        t_rate();
        t_master();
        t_slave();
        t_reject();
        summarize();
    end
endmodule
